// ==== rtl/synth_control_pin_logic.sv ====
`default_nettype none
`include "synth_consts.svh"

module synth_control_pin_logic
  import synth_pkg::*;
#(
  parameter logic [3:0] UD_PULSE = `UD_PULSE_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic SERIAL_CLK_WRITE_STROBE,
  input wire logic SERIAL_SELECT_N_READ_STROBE,
  input wire logic PARALLEL_SELECT,
  input wire logic [`ADDR_W-1:0] ADDR_IN,
  output logic SERIAL_READ_OUT,
  output logic SERIAL_READ_OE_N,
  output logic SDIO_OUT,
  output logic SDIO_OE_N,
  input wire logic [7:0] DATA_IN,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE_N,
  input wire logic UPDATE_STROBE_IN,
  output logic UPDATE_STROBE_OUT,
  output logic UPDATE_STROBE_OE_N,
  input wire logic SELECT_OR_FREEZE_INPUT,
  input wire logic SHAPED_KEYING,
  output logic [`TW_W-1:0] FREQ_WORD,
  output logic [`PH_W-1:0] PHASE_WORD,
  output logic [`AMP_W-1:0] AMPLITUDE
);

  localparam int MEM_W = `REG_COUNT * 8;
  localparam int SYNC_W = 22;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [SYNC_W-1:0] sync1_reg, sync1_next, sync2_reg, sync2_next;
  logic wrb_d_reg, ud_d_reg, wtog_d_reg, rtog_d_reg;
  logic wrb_d_next, ud_d_next, wtog_d_next, rtog_d_next;
  logic ser_wtog, ser_rtog;
  logic par_s, sel_s, key_s, ud_s, wrb_s, rdb_s, wtog_s, rtog_s;
  logic [`ADDR_W-1:0] addr_s;
  logic [7:0] data_s;

  always_comb begin
    sync1_next = {PARALLEL_SELECT, SELECT_OR_FREEZE_INPUT, SHAPED_KEYING, UPDATE_STROBE_IN,
                  SERIAL_CLK_WRITE_STROBE, SERIAL_SELECT_N_READ_STROBE, ADDR_IN, DATA_IN,
                  ser_wtog, ser_rtog};
    sync2_next = sync1_reg;
    wrb_d_next = wrb_s;
    ud_d_next = ud_s;
    wtog_d_next = wtog_s;
    rtog_d_next = rtog_s;
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      wrb_d_reg <= 1'h0;
      ud_d_reg <= 1'h0;
      wtog_d_reg <= 1'h0;
      rtog_d_reg <= 1'h0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      wrb_d_reg <= wrb_d_next;
      ud_d_reg <= ud_d_next;
      wtog_d_reg <= wtog_d_next;
      rtog_d_reg <= rtog_d_next;
    end
  end

  assign {par_s, sel_s, key_s, ud_s, wrb_s, rdb_s, addr_s, data_s, wtog_s, rtog_s} = sync2_reg;

  ////////////////////////////////////////////////////////////////////////////
  // serial port on its own clock

  logic master_clear_reg, master_clear_next;
  logic ser_off;
  ser_req_t ser_req;
  logic ser_rd_phase;
  logic [2:0] ser_out_idx;

  // high select, bus reset, parallel mode or master reset all idle the frame logic
  assign ser_off = SERIAL_SELECT_N_READ_STROBE | ADDR_IN[2] | par_s | master_clear_reg;

  serial_shifter u_serial (
    .sclk(SERIAL_CLK_WRITE_STROBE),
    .frame_clear(ser_off),
    .master_clear(master_clear_reg),
    .sdio_in(ADDR_IN[0]),
    .req(ser_req),
    .wr_toggle(ser_wtog),
    .rd_toggle(ser_rtog),
    .rd_phase(ser_rd_phase),
    .out_idx(ser_out_idx)
  );

  ////////////////////////////////////////////////////////////////////////////
  // programming registers, write and read paths

  logic [MEM_W-1:0] mem_reg, mem_next;
  logic [7:0] ser_rd_reg, ser_rd_next;
  logic [7:0] dout_reg, dout_next;
  logic wr_done_reg, wr_done_next;
  logic wr_en;
  logic [`ADDR_W-1:0] wr_addr;
  logic [7:0] wr_data;
  logic par_wr, ser_wr, ser_rd;
  logic [7:0] ctrl;
  logic ud_out_mode, three_wire;

  function automatic logic [7:0] byte_at(input logic [MEM_W-1:0] m, input logic [`ADDR_W-1:0] a);
    byte_at = m[{a, 3'h0} +: 8];
  endfunction : byte_at

  function automatic prog_t gather(input logic [MEM_W-1:0] m);
    prog_t g;
    g.tw1 = m[`OFS_TW1 * 8 +: `TW_W];
    g.tw2 = m[`OFS_TW2 * 8 +: `TW_W];
    g.delta = m[`OFS_DELTA * 8 +: `TW_W];
    g.ph1 = m[`OFS_PH1 * 8 +: `PH_W];
    g.ph2 = m[`OFS_PH2 * 8 +: `PH_W];
    g.ramp = m[`OFS_RAMP * 8 +: `RATE_W];
    g.mode = mode_t'(m[`OFS_CTRL * 8 + `CTRL_MODE_LSB +: 2]);
    g.key_en = m[`OFS_CTRL * 8 + `CTRL_KEY_EN_BIT];
    return g;
  endfunction : gather

  assign par_wr = par_s & wrb_s & ~wrb_d_reg;
  assign ser_wr = ~par_s & (wtog_s ^ wtog_d_reg);
  assign ser_rd = ~par_s & (rtog_s ^ rtog_d_reg);
  assign wr_en = par_wr | ser_wr;
  assign wr_addr = par_s ? addr_s : ser_req.addr;
  assign wr_data = par_s ? data_s : ser_req.data;
  assign ctrl = byte_at(mem_reg, `OFS_CTRL);
  assign ud_out_mode = ctrl[`CTRL_UD_OUT_BIT];
  assign three_wire = ctrl[`CTRL_3WIRE_BIT];

  always_comb begin
    mem_next = mem_reg;
    if (wr_en) begin
      mem_next[{wr_addr, 3'h0} +: 8] = wr_data;
    end
    // serial request fields are quiet by the time the toggle edge is seen
    ser_rd_next = ser_rd ? byte_at(mem_reg, ser_req.addr) : ser_rd_reg;
    dout_next = byte_at(mem_reg, addr_s);
    wr_done_next = wr_en;
    master_clear_next = 1'h0;
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      mem_reg <= {`REG_COUNT{`REG_DEFAULT}};
      ser_rd_reg <= 8'h00;
      dout_reg <= 8'h00;
      wr_done_reg <= 1'h0;
      master_clear_reg <= 1'h1;
    end else begin
      mem_reg <= mem_next;
      ser_rd_reg <= ser_rd_next;
      dout_reg <= dout_next;
      wr_done_reg <= wr_done_next;
      master_clear_reg <= master_clear_next;
    end
  end

  // read enables come straight from the serial frame so the bit is on the pin before the next rising edge
  assign SERIAL_READ_OUT = ser_rd_reg[ser_out_idx];
  assign SERIAL_READ_OE_N = ~(~par_s & three_wire & ser_rd_phase);
  assign SDIO_OUT = ser_rd_reg[ser_out_idx];
  assign SDIO_OE_N = ~(~par_s & ~three_wire & ser_rd_phase);
  assign DATA_OUT = dout_reg;
  assign DATA_OE_N = ~(par_s & ~rdb_s);

  ////////////////////////////////////////////////////////////////////////////
  // update strobe, working registers and output words

  prog_t active_reg, active_next;
  logic [3:0] pulse_cnt_reg, pulse_cnt_next;
  logic ud_pulse_reg, ud_pulse_next;
  logic ud_oe_n_reg, ud_oe_n_next;
  logic [`TW_W-1:0] chirp_reg, chirp_next;
  logic [`TW_W-1:0] freq_reg, freq_next;
  logic [`PH_W-1:0] phase_reg, phase_next;
  logic upd_event;
  prog_t staged;

  // in output mode the device updates itself one cycle after every completed write
  assign upd_event = ud_out_mode ? wr_done_reg : (ud_s & ~ud_d_reg);
  assign staged = gather(mem_reg);

  always_comb begin
    active_next = upd_event ? staged : active_reg;
    pulse_cnt_next = pulse_cnt_reg;
    if (upd_event && ud_out_mode) begin
      pulse_cnt_next = UD_PULSE;
    end else if (pulse_cnt_reg != 4'h0) begin
      pulse_cnt_next = pulse_cnt_reg - 4'h1;
    end
    ud_pulse_next = (pulse_cnt_next != 4'h0) & ud_out_mode;
    ud_oe_n_next = ~ud_out_mode;
    chirp_next = chirp_reg;
    if (upd_event) begin
      chirp_next = staged.tw1;
    end else if (active_reg.mode == MODE_CHIRP && !sel_s) begin
      chirp_next = chirp_reg + active_reg.delta;
    end
    case (active_reg.mode)
      MODE_FSK: freq_next = sel_s ? active_reg.tw2 : active_reg.tw1;
      MODE_CHIRP: freq_next = chirp_reg;
      default: freq_next = active_reg.tw1;
    endcase
    phase_next = (active_reg.mode == MODE_BPSK && sel_s) ? active_reg.ph2 : active_reg.ph1;
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      active_reg <= '0;
      pulse_cnt_reg <= 4'h0;
      ud_pulse_reg <= 1'h0;
      ud_oe_n_reg <= 1'h1;
      chirp_reg <= '0;
      freq_reg <= '0;
      phase_reg <= '0;
    end else begin
      active_reg <= active_next;
      pulse_cnt_reg <= pulse_cnt_next;
      ud_pulse_reg <= ud_pulse_next;
      ud_oe_n_reg <= ud_oe_n_next;
      chirp_reg <= chirp_next;
      freq_reg <= freq_next;
      phase_reg <= phase_next;
    end
  end

  assign UPDATE_STROBE_OUT = ud_pulse_reg;
  assign UPDATE_STROBE_OE_N = ud_oe_n_reg;
  assign FREQ_WORD = freq_reg;
  assign PHASE_WORD = phase_reg;

  keying_ramp #(
    .AMP_W(`AMP_W),
    .RATE_W(`RATE_W)
  ) u_keying (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .enable(active_reg.key_en),
    .key_level(key_s),
    .rate(active_reg.ramp),
    .amp(AMPLITUDE)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_upd_fire;
    ud_out_mode && upd_event;
  endsequence

  sequence s_quiet_after;
    (!upd_event && ud_out_mode) [*8];
  endsequence

  property p_ud_pulse;
    @(posedge CORE_CLK) disable iff (SYS_RST)
      s_upd_fire ##1 s_quiet_after |-> UPDATE_STROBE_OUT && $past(UPDATE_STROBE_OUT, 7) ##1 !UPDATE_STROBE_OUT;
  endproperty
  a_ud_pulse: assert property (p_ud_pulse) else $error("update pulse length is not eight");

  property p_ud_high;
    @(posedge CORE_CLK) disable iff (SYS_RST) s_upd_fire |=> UPDATE_STROBE_OUT;
  endproperty
  a_ud_high: assert property (p_ud_high) else $error("update pulse did not start");

  property p_ud_dir;
    @(posedge CORE_CLK) disable iff (SYS_RST) $changed(ud_out_mode) |=> UPDATE_STROBE_OE_N == !$past(ud_out_mode);
  endproperty
  a_ud_dir: assert property (p_ud_dir) else $error("update pin direction wrong");

  property p_ud_copy;
    @(posedge CORE_CLK) disable iff (SYS_RST) (!ud_out_mode && ud_s && !ud_d_reg) |=> active_reg == $past(staged);
  endproperty
  a_ud_copy: assert property (p_ud_copy) else $error("update edge did not copy registers");

  property p_fsk;
    @(posedge CORE_CLK) disable iff (SYS_RST)
      active_reg.mode == MODE_FSK |=> FREQ_WORD == ($past(sel_s) ? $past(active_reg.tw2) : $past(active_reg.tw1));
  endproperty
  a_fsk: assert property (p_fsk) else $error("wrong tuning word selected");

  property p_bpsk;
    @(posedge CORE_CLK) disable iff (SYS_RST)
      active_reg.mode == MODE_BPSK |=> PHASE_WORD == ($past(sel_s) ? $past(active_reg.ph2) : $past(active_reg.ph1));
  endproperty
  a_bpsk: assert property (p_bpsk) else $error("wrong phase word selected");

  property p_hold;
    @(posedge CORE_CLK) disable iff (SYS_RST)
      (active_reg.mode == MODE_CHIRP && sel_s && !upd_event) |=> $stable(chirp_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("chirp moved during hold");

  property p_par_write;
    @(posedge CORE_CLK) disable iff (SYS_RST) par_wr |=> byte_at(mem_reg, $past(addr_s)) == $past(data_s);
  endproperty
  a_par_write: assert property (p_par_write) else $error("parallel write not stored");

  property p_serial_idle_par;
    @(posedge CORE_CLK) disable iff (SYS_RST) par_s |-> SERIAL_READ_OE_N && SDIO_OE_N && !ser_wr;
  endproperty
  a_serial_idle_par: assert property (p_serial_idle_par) else $error("serial active in parallel mode");

  property p_master_reset;
    @(posedge CORE_CLK) SYS_RST |=> mem_reg == {`REG_COUNT{`REG_DEFAULT}} && master_clear_reg;
  endproperty
  a_master_reset: assert property (p_master_reset) else $error("registers not defaulted by reset");

endmodule : synth_control_pin_logic

`default_nettype wire

// ==== rtl/synth_consts.svh ====
`ifndef SYNTH_CONSTS_SVH
`define SYNTH_CONSTS_SVH

// widths and sizes
`define ADDR_W 6
`define REG_COUNT 64
`define TW_W 48
`define PH_W 14
`define AMP_W 12
`define RATE_W 8

// programming register byte offsets (multi-byte fields are least significant byte first)
`define OFS_PH1 6'h00
`define OFS_PH2 6'h02
`define OFS_TW1 6'h04
`define OFS_TW2 6'h0A
`define OFS_DELTA 6'h10
`define OFS_RAMP 6'h1A
`define OFS_CTRL 6'h1F

// control register fields
`define CTRL_MODE_LSB 0
`define CTRL_UD_OUT_BIT 2
`define CTRL_KEY_EN_BIT 3
`define CTRL_3WIRE_BIT 4

// reset and fixed values
`define REG_DEFAULT 8'h00
`define AMP_FULL 12'hFFF
`define AMP_ZERO 12'h000
`define UD_PULSE_CYCLES 4'h8

// serial frame: eight instruction bits then eight data bits
`define SER_INSTR_LAST 4'h7
`define SER_DATA_LAST 4'hF
`define SER_RW_POS 6

`endif

// ==== rtl/synth_pkg.sv ====
`default_nettype none
`include "synth_consts.svh"

package synth_pkg;

  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_FSK,
    MODE_BPSK,
    MODE_CHIRP
  } mode_t;

  typedef struct packed {
    logic [`TW_W-1:0] tw1;
    logic [`TW_W-1:0] tw2;
    logic [`TW_W-1:0] delta;
    logic [`PH_W-1:0] ph1;
    logic [`PH_W-1:0] ph2;
    logic [`RATE_W-1:0] ramp;
    mode_t mode;
    logic key_en;
  } prog_t;

  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic [7:0] data;
  } ser_req_t;

endpackage : synth_pkg

`default_nettype wire

// ==== rtl/serial_shifter.sv ====
`default_nettype none
`include "synth_consts.svh"

module serial_shifter
  import synth_pkg::*;
(
  input wire logic sclk,
  input wire logic frame_clear,
  input wire logic master_clear,
  input wire logic sdio_in,
  output ser_req_t req,
  output logic wr_toggle,
  output logic rd_toggle,
  output logic rd_phase,
  output logic [2:0] out_idx
);

  logic [3:0] cnt_reg, cnt_next;
  logic [6:0] shift_reg, shift_next;
  logic rd_mode_reg, rd_mode_next;
  ser_req_t req_reg, req_next;
  logic wr_tog_reg, wr_tog_next;
  logic rd_tog_reg, rd_tog_next;

  always_comb begin
    cnt_next = cnt_reg + 4'h1;
    shift_next = {shift_reg[5:0], sdio_in};
    rd_mode_next = rd_mode_reg;
    req_next = req_reg;
    wr_tog_next = wr_tog_reg;
    rd_tog_next = rd_tog_reg;
    if (cnt_reg == `SER_INSTR_LAST) begin
      rd_mode_next = shift_reg[`SER_RW_POS];
      req_next.addr = {shift_reg[4:0], sdio_in};
      if (shift_reg[`SER_RW_POS]) begin
        rd_tog_next = ~rd_tog_reg;
      end
    end else if (cnt_reg == `SER_DATA_LAST) begin
      rd_mode_next = 1'h0;
      if (!rd_mode_reg) begin
        req_next.data = {shift_reg, sdio_in};
        wr_tog_next = ~wr_tog_reg;
      end
    end
  end

  // frame state is cleared whenever the select line is high or the bus is reset
  always_ff @(posedge sclk or posedge frame_clear) begin
    if (frame_clear) begin
      cnt_reg <= 4'h0;
      shift_reg <= 7'h00;
      rd_mode_reg <= 1'h0;
    end else begin
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      rd_mode_reg <= rd_mode_next;
    end
  end

  // toggles survive a frame clear, otherwise the core would see a false event
  always_ff @(posedge sclk or posedge master_clear) begin
    if (master_clear) begin
      req_reg <= '0;
      wr_tog_reg <= 1'h0;
      rd_tog_reg <= 1'h0;
    end else begin
      req_reg <= req_next;
      wr_tog_reg <= wr_tog_next;
      rd_tog_reg <= rd_tog_next;
    end
  end

  assign req = req_reg;
  assign wr_toggle = wr_tog_reg;
  assign rd_toggle = rd_tog_reg;
  assign rd_phase = rd_mode_reg & cnt_reg[3];
  assign out_idx = ~cnt_reg[2:0];

  property p_rd_request;
    @(posedge sclk) disable iff (frame_clear || master_clear)
      (cnt_reg == `SER_INSTR_LAST && shift_reg[`SER_RW_POS])
      |=> (rd_toggle != $past(rd_toggle)) && rd_phase && (out_idx == 3'h7);
  endproperty
  a_rd_request: assert property (p_rd_request) else $error("read instruction not raised");

  // the next serial edge usually belongs to a later frame, so a select pulse must not abort this check
  property p_wr_capture;
    @(posedge sclk) disable iff (master_clear)
      (cnt_reg == `SER_DATA_LAST && !rd_mode_reg)
      |=> (req.data[0] == $past(sdio_in)) && (req.data[7:1] == $past(shift_reg)) &&
          (wr_toggle != $past(wr_toggle));
  endproperty
  a_wr_capture: assert property (p_wr_capture) else $error("serial write byte wrong");

endmodule : serial_shifter

`default_nettype wire

// ==== rtl/keying_ramp.sv ====
`default_nettype none
`include "synth_consts.svh"

module keying_ramp
  import synth_pkg::*;
#(
  parameter int AMP_W = `AMP_W,
  parameter int RATE_W = `RATE_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic key_level,
  input wire logic [RATE_W-1:0] rate,
  output logic [AMP_W-1:0] amp
);

  localparam logic [AMP_W-1:0] FULL = AMP_W'(`AMP_FULL);
  localparam logic [AMP_W-1:0] ZERO = AMP_W'(`AMP_ZERO);

  logic [RATE_W-1:0] div_reg, div_next;
  logic [AMP_W-1:0] amp_reg, amp_next;

  // one amplitude step every rate+1 cycles
  always_comb begin
    div_next = div_reg;
    amp_next = amp_reg;
    if (!enable) begin
      amp_next = FULL;
      div_next = '0;
    end else if (div_reg == rate) begin
      div_next = '0;
      if (key_level && amp_reg != FULL) begin
        amp_next = amp_reg + 1'b1;
      end else if (!key_level && amp_reg != ZERO) begin
        amp_next = amp_reg - 1'b1;
      end
    end else begin
      div_next = div_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_reg <= '0;
      amp_reg <= FULL;
    end else begin
      div_reg <= div_next;
      amp_reg <= amp_next;
    end
  end

  assign amp = amp_reg;

  property p_key_off;
    @(posedge clk) disable iff (rst) !enable |=> amp == FULL;
  endproperty
  a_key_off: assert property (p_key_off) else $error("keying acted while disabled");

  property p_key_up;
    @(posedge clk) disable iff (rst)
      (enable && key_level && div_reg == rate && amp_reg != FULL) |=> amp == $past(amp_reg) + 1'b1;
  endproperty
  a_key_up: assert property (p_key_up) else $error("ramp up step missing");

  property p_key_down;
    @(posedge clk) disable iff (rst)
      (enable && !key_level && div_reg == rate && amp_reg != ZERO) |=> amp == $past(amp_reg) - 1'b1;
  endproperty
  a_key_down: assert property (p_key_down) else $error("ramp down step missing");

endmodule : keying_ramp

`default_nettype wire

// ==== testbench/host_model.sv ====
`default_nettype none

module host_model (
  input wire logic clk,
  input wire logic sdio_out,
  input wire logic sro,
  input wire logic [7:0] dout,
  input wire logic doe_n,
  output logic sclk,
  output logic csn,
  output logic [5:0] addr,
  output logic [7:0] data
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sclk = 1'b0;
    csn = 1'b1;
    addr = 6'h00;
    data = 8'h00;
  end

  ////////////////////////////////////////
  task automatic par_wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    addr = a;
    data = d;
    repeat (3) @(posedge clk);
    #1 sclk = 1'b1;
    repeat (4) @(posedge clk);
    #1 sclk = 1'b0;
    repeat (4) @(posedge clk);
    // released bus shows inverted data so a late capture is visible
    #1 data = ~d;
  endtask : par_wr

  task automatic par_rd(input logic [5:0] a, output logic [7:0] r, output logic oe_n);
    @(posedge clk) #1 addr = a;
    repeat (3) @(posedge clk);
    #1 csn = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    r = dout;
    oe_n = doe_n;
    csn = 1'b1;
    repeat (4) @(posedge clk);
  endtask : par_rd

  // a select pulse or a bus reset pulse ends a cut frame; both stand long enough to be seen
  task automatic ser_end(input logic bus_reset);
    addr[2] = bus_reset;
    csn = ~bus_reset;
    #100 addr[2] = 1'b0;
  endtask : ser_end

  // serial clock moves only inside a frame; select stays low after a partial frame
  task automatic ser(input logic [15:0] w, input int n, input logic three, output logic [7:0] r);
    r = 8'h00;
    // the last parallel address may leave the bus reset line high
    addr = 6'h00;
    csn = 1'b0;
    #20;
    for (int i = 0; i < n; i++) begin
      if (i == 8) #150;
      addr[0] = (i < 8 || !w[15]) ? w[15 - i] : ~addr[0];
      #15;
      if (i >= 8) r = {r[6:0], three ? sro : sdio_out};
      sclk = 1'b1;
      #15 sclk = 1'b0;
    end
    #20;
    if (n == 16) csn = 1'b1;
    repeat (8) @(posedge clk);
  endtask : ser
endmodule : host_model

`default_nettype wire

// ==== testbench/synth_control_pin_logic_bench.sv ====
`default_nettype none
`include "synth_consts.svh"

module synth_control_pin_logic_bench;
  import synth_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [47:0] TW1 = 48'h123456789ABC;
  localparam logic [47:0] TW2 = 48'hFEDCBA987654;
  localparam logic [47:0] PH1 = 48'h1234;
  localparam logic [47:0] PH2 = 48'h2ABC;
  localparam logic [15:0] RD = {2'b10, `OFS_RAMP, 8'h00};
  logic core_clk, sys_rst, psel, upd, sel, key, sclk, csn, sro, sro_oe_n, sdio, sdio_oe_n, ud_out, ud_oe_n, doe_n;
  logic [5:0] addr;
  logic [7:0] hdata, dout, r;
  logic [47:0] fw;
  logic [13:0] pw;
  logic [11:0] amp;
  logic oe;
  int fails, total_checks, n;

  synth_control_pin_logic DUT (
    .CORE_CLK(core_clk), .SYS_RST(sys_rst), .SERIAL_CLK_WRITE_STROBE(sclk), .SERIAL_SELECT_N_READ_STROBE(csn),
    .PARALLEL_SELECT(psel), .ADDR_IN({addr[5:2], sro_oe_n ? addr[1] : sro, sdio_oe_n ? addr[0] : sdio}),
    .SERIAL_READ_OUT(sro), .SERIAL_READ_OE_N(sro_oe_n), .SDIO_OUT(sdio), .SDIO_OE_N(sdio_oe_n),
    .DATA_IN(doe_n ? hdata : dout), .DATA_OUT(dout), .DATA_OE_N(doe_n),
    .UPDATE_STROBE_IN(ud_oe_n ? upd : ud_out), .UPDATE_STROBE_OUT(ud_out), .UPDATE_STROBE_OE_N(ud_oe_n),
    .SELECT_OR_FREEZE_INPUT(sel), .SHAPED_KEYING(key), .FREQ_WORD(fw), .PHASE_WORD(pw), .AMPLITUDE(amp)
  );

  host_model host (
    .clk(core_clk), .sdio_out(sdio), .sro(sro), .dout(dout), .doe_n(doe_n),
    .sclk(sclk), .csn(csn), .addr(addr), .data(hdata)
  );

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  ////////////////////////////////////////
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  // multi-byte fields go least significant byte first
  task automatic wrn(input logic [5:0] a, input logic [47:0] v, input int nb);
    for (int i = 0; i < nb; i++) host.par_wr(6'(a + i), v[8 * i +: 8]);
  endtask : wrn

  task automatic update();
    @(posedge core_clk) #1 upd = 1'b1;
    repeat (4) @(posedge core_clk);
    #1 upd = 1'b0;
    repeat (8) @(posedge core_clk);
  endtask : update

  task automatic level(input logic s);
    @(posedge core_clk) #1 sel = s;
    repeat (8) @(posedge core_clk);
  endtask : level

  initial begin
    repeat (100000) @(posedge core_clk);
    fails++;
    results();
  end

  ////////////////////////////////////////
  initial begin
    fails = 0;
    total_checks = 0;
    {sys_rst, psel, upd, sel, key} = 5'h18;
    repeat (10) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    repeat (6) @(posedge core_clk);
    check("amplitude", amp, 48'hFFF);
    check("freq", fw, 48'h0);
    check("update oe_n", ud_oe_n, 48'h1);
    wrn(`OFS_TW1, TW1, 6);
    wrn(`OFS_TW2, TW2, 6);
    wrn(`OFS_CTRL, 48'h01, 1);
    check("freq before update", fw, 48'h0);
    update();
    check("fsk low", fw, TW1);
    level(1'b1);
    check("fsk high", fw, TW2);
    host.par_rd(6'h05, r, oe);
    check("read byte", r, TW1[15:8]);
    check("read oe_n", oe, 48'h0);
    $display("parallel fsk test done");
    wrn(`OFS_PH1, PH1, 2);
    wrn(`OFS_PH2, PH2, 2);
    wrn(`OFS_CTRL, 48'h02, 1);
    update();
    check("bpsk high", pw, PH2);
    level(1'b0);
    check("bpsk low", pw, PH1);
    wrn(`OFS_DELTA, 48'h1, 6);
    wrn(`OFS_CTRL, 48'h03, 1);
    level(1'b1);
    update();
    repeat (10) @(posedge core_clk);
    check("chirp hold", fw, TW1);
    level(1'b0);
    check("chirp runs", fw !== TW1, 48'h1);
    $display("mode test done");
    wrn(`OFS_RAMP, 48'h0, 1);
    wrn(`OFS_CTRL, 48'h08, 1);
    update();
    repeat (4200) @(posedge core_clk);
    check("ramp down", amp, 48'h0);
    @(posedge core_clk) #1 key = 1'b1;
    repeat (4200) @(posedge core_clk);
    check("ramp up", amp, 48'hFFF);
    $display("keying test done");
    wrn(`OFS_CTRL, 48'h04, 1);
    repeat (20) @(posedge core_clk);
    check("update oe_n", ud_oe_n, 48'h0);
    n = 0;
    fork
      wrn(`OFS_RAMP, 48'h01, 1);
      repeat (40) begin
        @(posedge core_clk);
        #1 n = n + int'(ud_out);
      end
    join
    check("pulse cycles", 48'(n), 48'h8);
    wrn(`OFS_CTRL, 48'h00, 1);
    $display("update pin test done");
    @(posedge core_clk) #1 psel = 1'b0;
    repeat (6) @(posedge core_clk);
    host.ser({2'b00, `OFS_RAMP, 8'hA5}, 16, 1'b0, r);
    host.ser(RD, 16, 1'b0, r);
    check("two-wire read", r, 48'hA5);
    host.ser({2'b00, `OFS_CTRL, 8'h10}, 16, 1'b0, r);
    host.ser(RD, 16, 1'b1, r);
    check("three-wire read", r, 48'hA5);
    check("serial oe_n idle", {sro_oe_n, sdio_oe_n}, 48'h3);
    host.ser({2'b00, `OFS_RAMP, 8'h3C}, 12, 1'b0, r);
    host.ser_end(1'b0);
    host.ser(RD, 16, 1'b1, r);
    check("aborted frame", r, 48'hA5);
    host.ser({2'b00, `OFS_RAMP, 8'h3C}, 12, 1'b0, r);
    host.ser_end(1'b1);
    host.ser(RD, 16, 1'b1, r);
    check("bus reset", r, 48'hA5);
    $display("serial test done");
    @(posedge core_clk) #1 sys_rst = 1'b1;
    repeat (3) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    repeat (6) @(posedge core_clk);
    check("freq after reset", fw, 48'h0);
    results();
  end
endmodule : synth_control_pin_logic_bench

`default_nettype wire
